// [logic/cmd_frame_pkg.sv]
package cmd_frame_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned GAP_TIMEOUT_US = 1000;
   localparam int unsigned GAP_TIMEOUT_CYC = GAP_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned FULL_FRAME_LEN = 9;
   localparam int unsigned CAN_FRAME_LEN = 7;
   localparam logic [3:0] POS_CODE = 4'h1;
   localparam logic [3:0] POS_TYPE = 4'h2;
   localparam logic [3:0] POS_AXIS = 4'h3;
   localparam logic [3:0] POS_VAL0 = 4'h4;
   localparam logic [3:0] POS_CSUM = 4'h8;
   localparam logic [7:0] ST_OK = 8'h64;
   localparam logic [7:0] ST_STORED = 8'h65;
   localparam logic [7:0] ST_BAD_CSUM = 8'h01;
   localparam logic [7:0] ST_BAD_CMD = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE = 8'h04;
   localparam logic [7:0] ST_CFG_LOCKED = 8'h05;
   localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FIFO_WIDTH = 8;
endpackage

// [logic/byte_fifo.sv]
`timescale 1ns/1ps
module byte_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_ent
         always_ff @(posedge ref_clk)
         begin
            if (push && wr_q == AW'(gi))
               mem_q[gi] <= in_data;
         end
      end
   endgenerate
endmodule

// [logic/motion_command_frame_handler.sv]
`timescale 1ns/1ps
module motion_command_frame_handler (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration
   input wire logic [7:0] module_addr,
   input wire logic [7:0] reply_addr,
   input wire logic can_mode,
   // received byte stream
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   // decoded command to the executor
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_type,
   output logic [7:0] cmd_axis,
   output logic [31:0] cmd_value,
   // executor result
   input wire logic exec_done,
   input wire logic [7:0] exec_status,
   input wire logic [31:0] exec_value,
   // transmitted byte stream
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_drive
);
   typedef enum logic [1:0] {RX, EXEC, TX} state_t;

   // ******************************************************
   // input buffer
   // ******************************************************
   logic f_valid;
   logic f_ready;
   logic [7:0] f_data;
   logic in_rdy;
   logic rx_ready_q;
   // registered ready drops for a cycle after each byte, so it never promises room the buffer lacks
   wire rx_push = rx_valid && rx_ready_q;
   byte_fifo #(.WIDTH(cmd_frame_pkg::FIFO_WIDTH), .DEPTH(cmd_frame_pkg::FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(rx_push),
      .in_ready(in_rdy),
      .in_data(rx_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // ******************************************************
   // receive framing
   // ******************************************************
   state_t st_q;
   logic [3:0] idx_q;
   logic [7:0] sum_q;
   logic [7:0] addr_q;
   logic [31:0] gap_q;
   logic mid_q;
   logic cmd_valid_q;
   logic [7:0] code_q;
   logic [7:0] type_q;
   logic [7:0] axis_q;
   logic [31:0] val_q;
   wire take = f_valid && f_ready;
   assign f_ready = (st_q == RX);
   // can frames start at the code byte and stop after the value
   wire [3:0] first_idx = can_mode ? cmd_frame_pkg::POS_CODE : 4'h0;
   wire [3:0] last_idx = can_mode ? cmd_frame_pkg::POS_CSUM - 4'h1 : cmd_frame_pkg::POS_CSUM;
   // position of the byte on offer; a fresh frame always starts at the mode's first position
   wire [3:0] pos = mid_q ? idx_q : first_idx;
   wire frame_end = take && pos == last_idx;
   wire csum_ok = can_mode || f_data == sum_q;
   wire addr_ok = can_mode || addr_q == module_addr;
   wire gap_expired = gap_q >= 32'(cmd_frame_pkg::GAP_TIMEOUT_CYC);
   wire accept = frame_end && addr_ok;
   wire [31:0] val_next = {val_q[23:0], f_data};

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx_q <= 4'h0;
         mid_q <= 1'b0;
         sum_q <= 8'h00;
         addr_q <= 8'h00;
         gap_q <= 32'h0;
      end
      else if (take)
      begin
         idx_q <= pos + 4'h1;
         mid_q <= !frame_end;
         sum_q <= mid_q ? sum_q + f_data : f_data;
         gap_q <= 32'h0;
         if (pos == 4'h0)
            addr_q <= f_data;
      end
      else if (st_q == RX && mid_q)
      begin
         gap_q <= gap_q + 32'h1;
         if (gap_expired)
         begin
            mid_q <= 1'b0;
            gap_q <= 32'h0;
         end
      end
      else
      begin
         mid_q <= 1'b0;
         gap_q <= 32'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_q <= 8'h00;
         type_q <= 8'h00;
         axis_q <= 8'h00;
         val_q <= 32'h0;
      end
      else if (take)
      begin
         if (pos == cmd_frame_pkg::POS_CODE)
            code_q <= f_data;
         if (pos == cmd_frame_pkg::POS_TYPE)
            type_q <= f_data;
         if (pos == cmd_frame_pkg::POS_AXIS)
            axis_q <= f_data;
         if (pos >= cmd_frame_pkg::POS_VAL0 && pos < cmd_frame_pkg::POS_CSUM)
            val_q <= val_next;
      end
   end

   // ******************************************************
   // control sequence
   // ******************************************************
   logic [3:0] tx_idx_q;
   logic [7:0] st_code_q;
   logic [31:0] rep_val_q;
   logic [7:0] tx_sum_q;
   logic tx_valid_q;
   logic [7:0] tx_data_q;
   logic tx_drive_q;
   wire tx_fire = tx_valid_q && tx_ready;
   wire [3:0] tx_first = can_mode ? 4'h1 : 4'h0;
   wire [3:0] tx_last = can_mode ? 4'h7 : 4'h8;
   logic [7:0] tx_byte;
   always_comb
   begin
      unique case (tx_idx_q)
         4'h0: tx_byte = reply_addr;
         4'h1: tx_byte = module_addr;
         4'h2: tx_byte = st_code_q;
         4'h3: tx_byte = code_q;
         4'h4: tx_byte = rep_val_q[31:24];
         4'h5: tx_byte = rep_val_q[23:16];
         4'h6: tx_byte = rep_val_q[15:8];
         4'h7: tx_byte = rep_val_q[7:0];
         default: tx_byte = tx_sum_q;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= RX;
         cmd_valid_q <= 1'b0;
         st_code_q <= 8'h00;
         rep_val_q <= 32'h0;
         tx_idx_q <= 4'h0;
         tx_sum_q <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_data_q <= 8'h00;
         tx_drive_q <= 1'b0;
      end
      else
      begin
         cmd_valid_q <= 1'b0;
         unique case (st_q)
            RX:
               if (accept && csum_ok)
               begin
                  st_q <= EXEC;
                  cmd_valid_q <= 1'b1;
               end
               else if (accept)
               begin
                  // bad checksum is answered without executing
                  st_q <= TX;
                  st_code_q <= cmd_frame_pkg::ST_BAD_CSUM;
                  rep_val_q <= 32'h0;
                  tx_idx_q <= tx_first;
                  tx_sum_q <= 8'h00;
               end
            EXEC:
               if (exec_done)
               begin
                  st_q <= TX;
                  st_code_q <= exec_status;
                  rep_val_q <= exec_value;
                  tx_idx_q <= tx_first;
                  tx_sum_q <= 8'h00;
               end
            TX:
               if (!tx_valid_q)
               begin
                  tx_valid_q <= 1'b1;
                  tx_drive_q <= 1'b1;
                  tx_data_q <= tx_byte;
               end
               else if (tx_fire)
               begin
                  tx_sum_q <= tx_sum_q + tx_data_q;
                  tx_valid_q <= 1'b0;
                  if (tx_idx_q == tx_last)
                  begin
                     st_q <= RX;
                     tx_drive_q <= 1'b0;
                  end
                  else
                     tx_idx_q <= tx_idx_q + 4'h1;
               end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_ready_q <= 1'b0;
      else
         rx_ready_q <= in_rdy && !rx_push;
   end

   assign rx_ready = rx_ready_q;
   assign cmd_valid = cmd_valid_q;
   assign cmd_code = code_q;
   assign cmd_type = type_q;
   assign cmd_axis = axis_q;
   assign cmd_value = val_q;
   assign tx_valid = tx_valid_q;
   assign tx_data = tx_data_q;
   assign tx_drive = tx_drive_q;

   // ******************************************************
   // checks
   // ******************************************************
   chk_tx_only_reply: assert property (@(posedge ref_clk) disable iff (!rst_n) tx_valid |-> st_q == TX)
      else $error("transmit outside reply");
   chk_exec_before_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_q == EXEC && !exec_done) |=> st_q != TX)
      else $error("reply before execution done");
   chk_bad_addr_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (frame_end && !addr_ok) |=> st_q == RX)
      else $error("foreign frame not dropped");
   chk_csum_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_q == RX && accept && !csum_ok) |=> (st_q == TX && st_code_q == cmd_frame_pkg::ST_BAD_CSUM))
      else $error("checksum error status missing");
   chk_good_frame_exec: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_q == RX && accept && csum_ok) |=> (cmd_valid && st_q == EXEC))
      else $error("good frame not executed");
   chk_reply_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(tx_drive) |-> tx_data == (can_mode ? module_addr : reply_addr))
      else $error("reply does not open with its address byte");
   chk_value_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (take && pos == cmd_frame_pkg::POS_CSUM - 4'h1) |=> cmd_value[7:0] == $past(f_data))
      else $error("value byte order wrong");
   chk_gap_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_q == RX && !take && mid_q && gap_expired) |=> !mid_q)
      else $error("gap did not restart frame");
   chk_ready_has_room: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_ready |-> in_rdy)
      else $error("ready shown without buffer room");
endmodule

// [tb/host_model.sv]
`timescale 1ns/1ps
// ****
// host on the byte link
// ****
module host_model (
   // clock
   input wire logic ref_clk,
   // command bytes
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   // reply bytes
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   // slow sink
   input wire logic stall
);
   logic [7:0] got[$];
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   // a byte holds until taken; released data shows its inverse
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i])
      begin
         @(negedge ref_clk);
         rx_valid = 1'b1;
         rx_data = b[i];
         do @(posedge ref_clk); while (rx_ready !== 1'b1);
      end
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
   always @(negedge ref_clk)
      tx_ready <= stall ? ~tx_ready : 1'b1;
   always @(posedge ref_clk)
      if (tx_valid === 1'b1 && tx_ready)
         got.push_back(tx_data);
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   // ****
   // bench signals
   // ****
   logic ref_clk, rst_n, can_mode, rx_valid, rx_ready, cmd_valid, exec_done, tx_valid, tx_ready, tx_drive, stall;
   logic [7:0] module_addr, reply_addr, rx_data, cmd_code, cmd_type, cmd_axis, exec_status, tx_data, ex_c, ex_st;
   logic [31:0] cmd_value, exec_value, ex_v;
   logic [7:0] fr[$], rp[$];
   int n_fail = 0, compares = 0, n_cmd = 0;
   motion_command_frame_handler motion_command_frame_handler_i (.ref_clk, .rst_n, .module_addr, .reply_addr,
      .can_mode, .rx_valid, .rx_ready, .rx_data, .cmd_valid, .cmd_code, .cmd_type, .cmd_axis, .cmd_value,
      .exec_done, .exec_status, .exec_value, .tx_valid, .tx_ready, .tx_data, .tx_drive);
   host_model host_i (.ref_clk, .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data, .stall);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ****
   // executor
   // ****
   always @(posedge ref_clk)
      if (cmd_valid === 1'b1)
      begin
         n_cmd++;
         chk(cmd_code, ex_c);
         chk({cmd_type, cmd_axis}, 16'h5a3c);
         chk(cmd_value, ex_v);
         repeat (20) @(negedge ref_clk);
         chk(host_i.got.size(), 0);
         chk(tx_drive, 1'b0);
         exec_done = 1'b1;
         exec_status = ex_st;
         exec_value = ~ex_v;
         @(negedge ref_clk);
         exec_done = 1'b0;
      end
   // ****
   // scenarios
   // ****
   task automatic run(input logic [7:0] a, input logic [7:0] st, input logic [7:0] e, input logic [31:0] v,
      input int n);
      logic [7:0] s;
      logic [31:0] rv;
      int k, c0;
      c0 = n_cmd;
      ex_c = 8'h10 + st;
      ex_v = v;
      ex_st = st;
      host_i.got = {};
      fr = {ex_c, 8'h5a, 8'h3c, v[31:24], v[23:16], v[15:8], v[7:0]};
      rv = (e != 8'h00) ? 32'h0 : ~v;
      rp = {module_addr, (e != 8'h00) ? cmd_frame_pkg::ST_BAD_CSUM : st, ex_c, rv[31:24], rv[23:16], rv[15:8],
         rv[7:0]};
      if (!can_mode)
      begin
         fr.push_front(a);
         s = 8'h00;
         foreach (fr[i]) s += fr[i];
         fr.push_back(s + e);
         rp.push_front(reply_addr);
         s = 8'h00;
         foreach (rp[i]) s += rp[i];
         rp.push_back(s);
      end
      host_i.send(fr);
      k = 0;
      // next command only once the whole reply is in
      while (k < 400 && (n == 0 || host_i.got.size() != n || tx_drive !== 1'b0))
      begin
         @(posedge ref_clk);
         k++;
      end
      chk(tx_drive, 1'b0);
      chk(host_i.got.size(), n);
      chk(n_cmd - c0, (e == 8'h00 && n != 0));
      for (int i = 0; i < host_i.got.size(); i++)
         chk(host_i.got[i], rp[i]);
   endtask
   task automatic t_status();
      logic [7:0] codes[8] = '{cmd_frame_pkg::ST_OK, cmd_frame_pkg::ST_STORED, cmd_frame_pkg::ST_BAD_CSUM,
         cmd_frame_pkg::ST_BAD_CMD, cmd_frame_pkg::ST_BAD_TYPE, cmd_frame_pkg::ST_BAD_VALUE,
         cmd_frame_pkg::ST_CFG_LOCKED, cmd_frame_pkg::ST_NOT_AVAIL};
      for (int i = 0; i < 8; i++)
      begin
         stall = i[0];
         run(module_addr, codes[i], 8'h00, 32'h80c1_0203 + i, 9);
      end
      stall = 1'b0;
      $display("test status done");
   endtask
   task automatic t_errors();
      run(module_addr, cmd_frame_pkg::ST_OK, 8'h01, 32'hff00_00ff, 9);
      run(module_addr + 8'h01, cmd_frame_pkg::ST_OK, 8'h00, 32'h1, 0);
      @(negedge ref_clk);
      can_mode = 1'b1;
      run(8'h00, cmd_frame_pkg::ST_OK, 8'h00, 32'h0102_0304, 7);
      @(negedge ref_clk);
      can_mode = 1'b0;
      $display("test errors done");
   endtask
   // partial frame left half-received in the framing logic, then a reset in mid-run; the next frame must still land cleanly
   task automatic t_reset();
      logic [7:0] part[$];
      part = {module_addr, 8'h11, 8'h22};
      host_i.send(part);
      @(negedge ref_clk);
      rst_n = 1'b0;
      @(negedge ref_clk);
      chk(rx_ready, 1'b0);
      chk(tx_drive, 1'b0);
      chk(tx_valid, 1'b0);
      chk(cmd_valid, 1'b0);
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(rx_ready, 1'b1);
      run(module_addr, cmd_frame_pkg::ST_OK, 8'h00, 32'h1234_5678, 9);
      run(module_addr, cmd_frame_pkg::ST_BAD_VALUE, 8'h00, 32'h8000_0001, 9);
      $display("test reset done");
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("MISMATCH at %0t: watchdog ran out", $time);
      test_done();
   end
   initial
   begin
      {rst_n, can_mode, exec_done, stall} = 4'h0;
      {exec_status, exec_value} = 40'h0;
      module_addr = 8'h07;
      reply_addr = 8'h02;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      t_status();
      t_errors();
      t_reset();
      test_done();
   end
endmodule
